// ===== src/acrw_core.sv
// converter control slice: reference, window, flags, busy, apb
// What this block does
// - three-bit reference select: supply, external pin, four internal levels
// - switching to an internal reference waits 60 us before converting
// - window source bit picks result or sample low sixteen bits
// - window mode: off, below, above, inside, outside; rest reserved
// - sixteen-bit low and high thresholds in their own registers
// - six interrupt enables at bits five down to zero
// - flags clear on writing one; writing zero leaves them
// - trigger during a running conversion sets trigger overrun
// - new sample over an unread sample sets sample overwrite
// - new result over an unread result sets result overwrite
// - completion, or each new sample when the source bit picks the sample, with window condition met sets window match
// - new sample sets sample ready; sample read clears it
// - new result sets result ready; result read clears it
// - busy while converting or while reference settling pending
// - up to 1024 samples summed into result; sample keeps latest
//
// Register access over APB was left to the implementer.
module acrw_core
  import acrw_pkg::*;
#(
  parameter int REF_INIT_CYC = REF_INIT_CYCLES
)(
  input  logic        clk,
  input  logic        rst,
  input  logic        psel,
  input  logic        penable,
  input  logic        pwrite,
  input  logic [7:0]  paddr,
  input  logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic        pready,
  output logic        pslverr,
  input  logic        start_trigger,
  input  logic        sample_strobe,
  input  logic [15:0] sample_data,
  output logic        conv_go,
  output logic [2:0]  reference_select,
  output logic        converter_busy,
  output logic        irq
);

  // ************************************************
  // storage
  // ************************************************
  logic [2:0]         ref_sel_reg;
  logic               win_src_reg;
  logic [2:0]         win_mode_reg;
  logic [N_FLAGS-1:0] int_en_reg;
  logic [N_FLAGS-1:0] flags_reg;
  logic [N_FLAGS-1:0] flags_next;
  logic [3:0]         acc_code_reg;
  logic [15:0]        low_thr_reg;
  logic [15:0]        high_thr_reg;
  logic [31:0]        result_reg;
  logic [15:0]        sample_reg;
  logic [31:0]        acc_sum_reg;
  logic [10:0]        acc_cnt_reg;
  logic [15:0]        settle_cnt_reg;
  acrw_state_t        state_reg;
  logic               conv_go_reg;
  logic               busy_reg;
  logic               irq_reg;
  logic [31:0]        prdata_reg;
  logic               pready_reg;
  logic               pslverr_reg;

  // ************************************************
  // apb decode
  // ************************************************
  logic        setup;
  logic        access;
  logic        wr_en;
  logic        rd_en;
  logic [31:0] rd_mux;
  logic        mapped;

  assign setup  = psel & ~penable;
  assign access = psel & penable & pready_reg;
  assign wr_en  = access & pwrite;
  assign rd_en  = access & ~pwrite;

  always_comb begin
    rd_mux = 32'h0;
    mapped = 1'b1;
    if (paddr == addr_of(REF_CTRL_IDX)) begin
      rd_mux = {29'h0, ref_sel_reg};
    end else if (paddr == addr_of(WIN_CTRL_IDX)) begin
      rd_mux = {28'h0, win_src_reg, win_mode_reg};
    end else if (paddr == addr_of(INT_EN_IDX)) begin
      rd_mux = {26'h0, int_en_reg};
    end else if (paddr == addr_of(INT_FLAG_IDX)) begin
      rd_mux = {26'h0, flags_reg};
    end else if (paddr == addr_of(STATUS_IDX)) begin
      rd_mux = {31'h0, busy_reg};
    end else if (paddr == addr_of(ACC_CTRL_IDX)) begin
      rd_mux = {28'h0, acc_code_reg};
    end else if (paddr == addr_of(RESULT_IDX)) begin
      rd_mux = result_reg;
    end else if (paddr == addr_of(SAMPLE_IDX)) begin
      rd_mux = {16'h0, sample_reg};
    end else if (paddr == addr_of(LOW_THR_IDX)) begin
      rd_mux = {16'h0, low_thr_reg};
    end else if (paddr == addr_of(HIGH_THR_IDX)) begin
      rd_mux = {16'h0, high_thr_reg};
    end else begin
      mapped = 1'b0;
    end
  end

  // one wait-free access phase: data is latched in setup
  always_ff @(posedge clk) begin
    if (rst) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~mapped;
      if (setup && !pwrite) begin
        prdata_reg <= rd_mux;
      end
    end
  end

  // ************************************************
  // control registers
  // ************************************************
  logic wr_ref;
  logic ref_load;

  assign wr_ref   = wr_en && paddr == addr_of(REF_CTRL_IDX);
  assign ref_load = wr_ref && pwdata[2] && pwdata[2:0] != ref_sel_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ref_sel_reg  <= RST_BYTE[2:0];
      win_src_reg  <= RST_BYTE[WIN_SRC_BIT];
      win_mode_reg <= RST_BYTE[2:0];
      int_en_reg   <= RST_BYTE[N_FLAGS-1:0];
      acc_code_reg <= RST_BYTE[3:0];
      low_thr_reg  <= 16'h0;
      high_thr_reg <= 16'h0;
    end else begin
      if (wr_ref) begin
        ref_sel_reg <= pwdata[2:0];
      end
      if (wr_en && paddr == addr_of(WIN_CTRL_IDX)) begin
        win_src_reg  <= pwdata[WIN_SRC_BIT];
        win_mode_reg <= pwdata[2:0];
      end
      if (wr_en && paddr == addr_of(INT_EN_IDX)) begin
        int_en_reg <= pwdata[N_FLAGS-1:0];
      end
      if (wr_en && paddr == addr_of(ACC_CTRL_IDX)) begin
        acc_code_reg <= pwdata[3:0];
      end
      if (wr_en && paddr == addr_of(LOW_THR_IDX)) begin
        low_thr_reg <= pwdata[15:0];
      end
      if (wr_en && paddr == addr_of(HIGH_THR_IDX)) begin
        high_thr_reg <= pwdata[15:0];
      end
    end
  end

  // ************************************************
  // reference settling
  // ************************************************
  logic settled;

  assign settled = settle_cnt_reg == 16'h0;

  // count the init time after moving to an internal level
  always_ff @(posedge clk) begin
    if (rst) begin
      settle_cnt_reg <= 16'h0;
    end else if (ref_load) begin
      settle_cnt_reg <= 16'(REF_INIT_CYC);
    end else if (!settled) begin
      settle_cnt_reg <= settle_cnt_reg - 16'h1;
    end
  end

  // ************************************************
  // conversion sequencing and accumulation
  // ************************************************
  logic        conv_act;
  logic        samp_evt;
  logic        res_evt;
  logic        trig_ovr;
  logic [31:0] acc_sum_new;
  logic [10:0] acc_cnt_new;

  assign conv_act    = state_reg == ST_CONV;
  assign samp_evt    = conv_act & sample_strobe;
  assign acc_sum_new = acc_sum_reg + {16'h0, sample_data};
  assign acc_cnt_new = acc_cnt_reg + 11'h1;
  // result completes after the chosen number of samples
  assign res_evt     = samp_evt && acc_cnt_new == samples_needed(acc_code_reg);
  // trigger while the burst still runs
  assign trig_ovr    = conv_act & start_trigger;

  // a trigger during settling is held, not flagged: nothing converts yet
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg   <= ST_IDLE;
      conv_go_reg <= 1'b0;
    end else begin
      conv_go_reg <= 1'b0;
      case (state_reg)
        ST_IDLE: begin
          if (start_trigger) begin
            if (settled) begin
              conv_go_reg <= 1'b1;
              state_reg   <= ST_CONV;
            end else begin
              state_reg <= ST_WAIT_REF;
            end
          end
        end
        // hold the start until the reference is usable
        ST_WAIT_REF: begin
          if (settled) begin
            conv_go_reg <= 1'b1;
            state_reg   <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (res_evt) begin
            state_reg <= ST_IDLE;
          end else if (samp_evt) begin
            conv_go_reg <= 1'b1;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // sum into result, sample keeps the latest
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_sum_reg <= 32'h0;
      acc_cnt_reg <= 11'h0;
      result_reg  <= 32'h0;
      sample_reg  <= 16'h0;
    end else if (samp_evt) begin
      sample_reg <= sample_data;
      if (res_evt) begin
        result_reg  <= acc_sum_new;
        acc_sum_reg <= 32'h0;
        acc_cnt_reg <= 11'h0;
      end else begin
        acc_sum_reg <= acc_sum_new;
        acc_cnt_reg <= acc_cnt_new;
      end
    end
  end

  // ************************************************
  // window comparator
  // ************************************************
  acrw_win_if win ();

  // compare the value that is being stored
  assign win.value = win_src_reg ? sample_data : acc_sum_new[15:0];
  assign win.check = win_src_reg ? samp_evt : res_evt;
  assign win.low   = low_thr_reg;
  assign win.high  = high_thr_reg;
  assign win.mode  = win_mode_reg;

  acrw_window u_window (
    .w (win)
  );

  // ************************************************
  // flags and interrupt
  // ************************************************
  logic [N_FLAGS-1:0] flag_set;
  logic [N_FLAGS-1:0] flag_clr;
  logic               rd_sample;
  logic               rd_result;
  logic               wr_flags;

  assign rd_sample = rd_en && paddr == addr_of(SAMPLE_IDX);
  assign rd_result = rd_en && paddr == addr_of(RESULT_IDX);
  assign wr_flags  = wr_en && paddr == addr_of(INT_FLAG_IDX);

  always_comb begin
    flag_set = '0;
    flag_clr = '0;
    flag_set[FLAG_TRIG_OVR] = trig_ovr;
    // unread while sample ready still set
    flag_set[FLAG_SAMP_OVR] = samp_evt & flags_reg[FLAG_SAMP_RDY];
    // unread while result ready still set
    flag_set[FLAG_RES_OVR]  = res_evt & flags_reg[FLAG_RES_RDY];
    flag_set[FLAG_WIN]      = win.match;
    flag_set[FLAG_SAMP_RDY] = samp_evt;
    flag_set[FLAG_RES_RDY]  = res_evt;
    if (wr_flags) begin
      flag_clr = pwdata[N_FLAGS-1:0];
    end
    flag_clr[FLAG_SAMP_RDY] = flag_clr[FLAG_SAMP_RDY] | rd_sample;
    flag_clr[FLAG_RES_RDY]  = flag_clr[FLAG_RES_RDY] | rd_result;
    // a new event in the clearing cycle survives
    flags_next = (flags_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      flags_reg <= RST_BYTE[N_FLAGS-1:0];
      irq_reg   <= 1'b0;
      busy_reg  <= 1'b0;
    end else begin
      flags_reg <= flags_next;
      // one level request from enabled flags
      irq_reg   <= |(flags_reg & int_en_reg);
      // busy from the state being entered, so it rises with conv_go
      busy_reg  <= (conv_act && !res_evt) || state_reg == ST_WAIT_REF
                   || (state_reg == ST_IDLE && start_trigger) || !settled || ref_load;
    end
  end

  assign prdata           = prdata_reg;
  assign pready           = pready_reg;
  assign pslverr          = pslverr_reg;
  assign conv_go          = conv_go_reg;
  assign reference_select = ref_sel_reg;
  assign converter_busy   = busy_reg;
  assign irq              = irq_reg;

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ref_hold_start_a: assert property (
    (state_reg == ST_WAIT_REF || (state_reg == ST_IDLE && start_trigger)) && !settled |=> !conv_go_reg)
    else $error("conversion started before reference settled");
  w1c_clear_a: assert property (
    wr_flags && pwdata[FLAG_TRIG_OVR] && !trig_ovr |=> !flags_reg[FLAG_TRIG_OVR])
    else $error("write one did not clear overrun");
  w1c_keep_a: assert property (
    wr_flags && !pwdata[FLAG_WIN] && flags_reg[FLAG_WIN] |=> flags_reg[FLAG_WIN])
    else $error("write zero changed window flag");
  trig_overrun_a: assert property (
    conv_act && start_trigger |=> flags_reg[FLAG_TRIG_OVR])
    else $error("overrun not flagged");
  samp_overwrite_a: assert property (
    samp_evt && flags_reg[FLAG_SAMP_RDY] |=> flags_reg[FLAG_SAMP_OVR])
    else $error("sample overwrite missed");
  res_overwrite_a: assert property (
    res_evt && flags_reg[FLAG_RES_RDY] |=> flags_reg[FLAG_RES_OVR] && result_reg == $past(acc_sum_new))
    else $error("result overwrite missed");
  win_off_a: assert property (
    (win_mode_reg == WIN_OFF || win_mode_reg > WIN_OUTSIDE) && !flags_reg[FLAG_WIN]
      && !(wr_en && paddr == addr_of(WIN_CTRL_IDX)) |=> !flags_reg[FLAG_WIN])
    else $error("window flag set while off");
  samp_read_a: assert property (
    rd_sample && !samp_evt |=> !flags_reg[FLAG_SAMP_RDY])
    else $error("sample read left ready set");
  res_ready_a: assert property (
    res_evt |=> flags_reg[FLAG_RES_RDY] ##1 irq_reg || !int_en_reg[FLAG_RES_RDY])
    else $error("result ready not raised");
  irq_level_a: assert property (
    !(|(flags_reg & int_en_reg)) |=> !irq_reg)
    else $error("interrupt without enabled flag");
  busy_conv_a: assert property (
    conv_go_reg |-> busy_reg)
    else $error("busy low during conversion");
  acc_count_a: assert property (
    samp_evt && !res_evt |=> acc_cnt_reg == $past(acc_cnt_new))
    else $error("accumulation count slipped");

  overrun_c: cover property (conv_act && start_trigger);
  accum_c:   cover property (res_evt && acc_code_reg != 4'h0);
  window_c:  cover property (win.match);
  irq_c:     cover property ($rose(irq_reg));

endmodule : acrw_core

// ===== src/acrw_pkg.sv
// shared constants and types for the converter control slice
package acrw_pkg;

  // ************************************************
  // register indices (byte address is four times)
  // ************************************************
  localparam logic [7:0] REF_CTRL_IDX  = 8'h02;
  localparam logic [7:0] WIN_CTRL_IDX  = 8'h03;
  localparam logic [7:0] INT_EN_IDX    = 8'h04;
  localparam logic [7:0] INT_FLAG_IDX  = 8'h05;
  localparam logic [7:0] STATUS_IDX    = 8'h06;
  localparam logic [7:0] ACC_CTRL_IDX  = 8'h09;
  localparam logic [7:0] RESULT_IDX    = 8'h10;
  localparam logic [7:0] SAMPLE_IDX    = 8'h14;
  localparam logic [7:0] LOW_THR_IDX   = 8'h1c;
  localparam logic [7:0] HIGH_THR_IDX  = 8'h1e;

  // ************************************************
  // field positions and reset values
  // ************************************************
  localparam int         N_FLAGS       = 6;
  localparam int         FLAG_TRIG_OVR = 5;
  localparam int         FLAG_SAMP_OVR = 4;
  localparam int         FLAG_RES_OVR  = 3;
  localparam int         FLAG_WIN      = 2;
  localparam int         FLAG_SAMP_RDY = 1;
  localparam int         FLAG_RES_RDY  = 0;
  localparam int         WIN_SRC_BIT   = 3;
  localparam logic [7:0] RST_BYTE      = 8'h00;
  localparam logic [3:0] ACC_MAX_CODE  = 4'ha;

  // reference codes
  localparam logic [2:0] REF_SUPPLY    = 3'h0;
  localparam logic [2:0] REF_EXTERNAL  = 3'h2;
  localparam logic [2:0] REF_1V024     = 3'h4;
  localparam logic [2:0] REF_2V048     = 3'h5;
  localparam logic [2:0] REF_4V096     = 3'h6;
  localparam logic [2:0] REF_2V500     = 3'h7;

  // ************************************************
  // timing
  // ************************************************
  localparam int REF_INIT_US     = 60;
  localparam int CLK_MHZ         = 100;
  localparam int REF_INIT_CYCLES = REF_INIT_US * CLK_MHZ;

  typedef enum logic [2:0] {
    WIN_OFF     = 3'b000,
    WIN_BELOW   = 3'b001,
    WIN_ABOVE   = 3'b010,
    WIN_INSIDE  = 3'b011,
    WIN_OUTSIDE = 3'b100
  } acrw_wmode_t;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_WAIT_REF = 2'b01,
    ST_CONV     = 2'b10
  } acrw_state_t;

  function automatic logic [7:0] addr_of(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction : addr_of

  // reserved codes above the largest count act as the largest
  function automatic logic [10:0] samples_needed(input logic [3:0] code);
    logic [3:0] c;
    c = (code > ACC_MAX_CODE) ? ACC_MAX_CODE : code;
    return 11'h001 << c;
  endfunction : samples_needed

endpackage : acrw_pkg

// ===== src/acrw_win_if.sv
// window comparator hookup between core and comparator
interface acrw_win_if;
  logic [15:0] value;
  logic [15:0] low;
  logic [15:0] high;
  logic [2:0]  mode;
  logic        check;
  logic        match;
  modport host (output value, low, high, mode, check, input match);
  modport cmp  (input value, low, high, mode, check, output match);
endinterface : acrw_win_if

// ===== src/acrw_window.sv
// window comparator: value against two thresholds
module acrw_window
  import acrw_pkg::*;
(
  acrw_win_if.cmp w
);

  // ************************************************
  // comparison
  // ************************************************
  logic below;
  logic above;

  assign below = w.value < w.low;
  assign above = w.value > w.high;

  // mode decode, reserved codes never match
  // off and reserved codes give no match
  always_comb begin
    case (w.mode)
      WIN_BELOW:   w.match = w.check & below;
      WIN_ABOVE:   w.match = w.check & above;
      WIN_INSIDE:  w.match = w.check & (w.value > w.low) & (w.value < w.high);
      WIN_OUTSIDE: w.match = w.check & (below | above);
      default:     w.match = 1'b0;
    endcase
  end

endmodule : acrw_window

// ===== test/test_adc_ref_window_irq_status.sv
// self-checking testbench for the converter control slice
module test_adc_ref_window_irq_status import acrw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************
  // signals and design
  // ************************************************
  // short settle keeps the run small; expectations follow it
  localparam int SETTLE = 20;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        start_trigger;
  logic        sample_strobe;
  logic [15:0] sample_data;
  logic        conv_go;
  logic [2:0]  reference_select;
  logic        converter_busy;
  logic        irq;
  int          error_cnt;
  int          checked;

  acrw_core #(.REF_INIT_CYC(SETTLE)) dut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .start_trigger(start_trigger), .sample_strobe(sample_strobe),
    .sample_data(sample_data), .conv_go(conv_go), .reference_select(reference_select),
    .converter_busy(converter_busy), .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ************************************************
  // shared tasks
  // ************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // request held until pready is sampled high, then released
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx[5:0], 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    apb(1'b0, idx, 32'h0, r, e);
    chk(r, exp);
  endtask : rchk

  // one conversion of n samples; ovr retriggers on the last sample
  task automatic conv(input int n, input logic [15:0] d0, input logic [15:0] d1,
                      input logic ovr, output int w0);
    int w;
    start_trigger <= 1'b1;
    @(posedge clk);
    start_trigger <= 1'b0;
    for (int i = 0; i < n; i++) begin
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (conv_go !== 1'b1);
      if (i == 0) w0 = w;
      sample_strobe <= 1'b1;
      sample_data   <= (i == 0) ? d0 : d1;
      start_trigger <= ovr && (i == n - 1);
      @(posedge clk);
      sample_strobe <= 1'b0;
      start_trigger <= 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask : conv

  task automatic ck_irq(input logic exp);
    @(posedge clk);
    chk(irq, exp);
  endtask : ck_irq

  function automatic logic win(input int m, input logic [15:0] v, input logic [15:0] lo,
                               input logic [15:0] hi);
    case (m)
      1: return v < lo;
      2: return v > hi;
      3: return (v > lo) && (v < hi);
      4: return (v < lo) || (v > hi);
      default: return 1'b0;
    endcase
  endfunction : win

  // ************************************************
  // scenarios
  // ************************************************
  task automatic t_reset();
    logic [31:0] r;
    logic        e;
    rchk(REF_CTRL_IDX, 32'h0);
    rchk(WIN_CTRL_IDX, 32'h0);
    rchk(INT_EN_IDX, 32'h0);
    rchk(INT_FLAG_IDX, 32'h0);
    rchk(STATUS_IDX, 32'h0);
    chk({irq, converter_busy, reference_select}, 32'h0);
    apb(1'b0, 8'h3f, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    wr(STATUS_IDX, 32'h1);
    rchk(STATUS_IDX, 32'h0);
  endtask : t_reset

  task automatic t_ref();
    int w;
    for (int c = 0; c < 8; c++) begin
      wr(REF_CTRL_IDX, c);
      chk(reference_select, c);
      rchk(REF_CTRL_IDX, c);
    end
    repeat (SETTLE + 5) @(posedge clk);
    wr(REF_CTRL_IDX, {29'h0, REF_SUPPLY});
    rchk(STATUS_IDX, 32'h0);
    wr(REF_CTRL_IDX, {29'h0, REF_1V024});
    chk(converter_busy, 1'b1);
    rchk(STATUS_IDX, 32'h1);
    conv(1, 16'h0001, 16'h0, 1'b0, w);
    chk(w >= 10 && w <= SETTLE + 2, 1'b1);
    wr(REF_CTRL_IDX, {29'h0, REF_EXTERNAL});
    conv(1, 16'h0002, 16'h0, 1'b0, w);
    chk(w, 1);
    rchk(STATUS_IDX, 32'h0);
  endtask : t_ref

  task automatic t_window();
    logic [15:0] vals [5];
    int          w;
    vals = '{16'h0050, 16'h0100, 16'h0150, 16'h0200, 16'h0250};
    wr(LOW_THR_IDX, 32'h100);
    wr(HIGH_THR_IDX, 32'h200);
    for (int m = 0; m < 8; m++) begin
      for (int k = 0; k < 5; k++) begin
        wr(WIN_CTRL_IDX, {k[0], m[2:0]});
        wr(INT_FLAG_IDX, 32'h3f);
        conv(1, vals[k], 16'h0, 1'b0, w);
        rchk(INT_FLAG_IDX, {win(m, vals[k], 16'h100, 16'h200), 2'b11});
      end
    end
  endtask : t_window

  task automatic t_acc();
    int w;
    wr(ACC_CTRL_IDX, 32'h1);
    wr(WIN_CTRL_IDX, {1'b1, WIN_BELOW});
    wr(INT_FLAG_IDX, 32'h3f);
    conv(2, 16'h0090, 16'h0090, 1'b0, w);
    rchk(INT_FLAG_IDX, 32'h17);
    wr(WIN_CTRL_IDX, {1'b0, WIN_BELOW});
    wr(INT_FLAG_IDX, 32'h3f);
    conv(2, 16'h0090, 16'h0091, 1'b0, w);
    rchk(INT_FLAG_IDX, 32'h13);
    rchk(RESULT_IDX, 32'h121);
    rchk(INT_FLAG_IDX, 32'h12);
    rchk(SAMPLE_IDX, 32'h91);
    rchk(INT_FLAG_IDX, 32'h10);
    wr(INT_FLAG_IDX, 32'h0);
    rchk(INT_FLAG_IDX, 32'h10);
    wr(INT_FLAG_IDX, 32'h10);
    rchk(INT_FLAG_IDX, 32'h0);
    wr(ACC_CTRL_IDX, 32'h0);
    wr(WIN_CTRL_IDX, 32'h0);
  endtask : t_acc

  task automatic t_ovr_irq();
    int w;
    conv(1, 16'h0005, 16'h0, 1'b0, w);
    conv(1, 16'h0006, 16'h0, 1'b1, w);
    rchk(INT_FLAG_IDX, 32'h3b);
    wr(INT_EN_IDX, 32'h04);
    ck_irq(1'b0);
    wr(INT_EN_IDX, 32'h20);
    ck_irq(1'b1);
    wr(INT_FLAG_IDX, 32'h20);
    ck_irq(1'b0);
    rchk(INT_FLAG_IDX, 32'h1b);
    wr(INT_EN_IDX, 32'h3f);
    ck_irq(1'b1);
    rchk(INT_EN_IDX, 32'h3f);
    wr(INT_FLAG_IDX, 32'h3f);
    ck_irq(1'b0);
    conv(1, 16'h0007, 16'h0, 1'b0, w);
    chk(irq, 1'b1);
    rchk(RESULT_IDX, 32'h7);
    rchk(SAMPLE_IDX, 32'h7);
    ck_irq(1'b0);
  endtask : t_ovr_irq

  // ************************************************
  // run control
  // ************************************************
  task automatic complete_run();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // whole run is under a thousand cycles; limit is far beyond it
  initial begin
    #400us;
    error_cnt++;
    complete_run();
  end

  initial begin
    error_cnt = 0;
    checked = 0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    start_trigger = 1'b0;
    sample_strobe = 1'b0;
    sample_data = 16'h0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_ref();
    t_window();
    t_acc();
    t_ovr_irq();
    complete_run();
  end
endmodule : test_adc_ref_window_irq_status
